// *** logic/sgsel_top.sv ***
// Setting group priority selector with classic Wishbone register slave
//
// Summary of operation
// [RL1] Up to eight selectable parameter groups
// [RL2] Reset: group one only, selection idle
// [RL3] Two or more groups: requests decide activation
// [RL4] Force enable ignores automatic requests entirely
// [RL5] Requests accepted as pulse or level
// [RL6] Fixed priority, group one highest wins
// [RL7] Two static levels: higher group active
// [RL8] Pulse-selected group stays until another request
// [RL9] Operator enables group and force first
// [RL10] Force release: held levels take over immediately
// [RL11] Active group reads one to eight, one after reset
// [RL12] Forced field none or group, acts latched
// [RL13] Force end without request keeps last group
// [RL14] Force default off; forced changes refused while off
// [RL15] Used group count; new groups load defaults
// [RL16] Remote change ignored below held level request
// [RL17] Held group one blocks all others
// [RL18] Held level blocks all lower groups
// [RL19] Held group eight blocks nobody
// [RL20] Rising edge detect, update within one cycle
`timescale 1ns/10ps

module sgsel_top
(
   input wire logic CORE_CLK,
   input wire logic SRST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [sgsel_pkg::ADR_W-1:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [sgsel_pkg::DAT_W-1:0] WB_DAT_I,
   output logic [sgsel_pkg::DAT_W-1:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic [sgsel_pkg::NUM_GROUPS-1:0] GROUP_REQUEST,
   output logic [sgsel_pkg::IDX_W-1:0] ACTIVE_GROUP,
   output logic [sgsel_pkg::NUM_GROUPS-1:0] ACTIVE_GROUP_ONEHOT,
   output logic FORCE_ACTIVE,
   output logic [sgsel_pkg::NUM_GROUPS-1:0] GROUP_LOAD_DEFAULTS
);

   localparam int N = sgsel_pkg::NUM_GROUPS;
   localparam int IW = sgsel_pkg::IDX_W;
   localparam int CW = sgsel_pkg::CODE_W;

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [N-1:0] sync1_reg;
   logic [N-1:0] sync2_reg;
   logic [N-1:0] sync3_reg;
   logic [N-1:0] level_reg;
   logic [N-1:0] level_next;
   logic [N-1:0] level_d_reg;
   logic ack_reg;
   logic [sgsel_pkg::DAT_W-1:0] rdata_reg;
   logic [sgsel_pkg::DAT_W-1:0] rdata_next;
   sgsel_pkg::sgsel_cfg_t cfg_reg;
   sgsel_pkg::sgsel_cfg_t cfg_next;
   logic force_en_d_reg;
   logic [IW-1:0] active_reg;
   logic [IW-1:0] active_next;
   logic [N-1:0] used_d_reg;
   logic [N-1:0] defaults_reg;
   logic [2:0] refuse_reg;
   logic [2:0] refuse_next;
   sgsel_pkg::sgsel_req_t force_req;
   sgsel_pkg::sgsel_req_t remote_req;
   sgsel_pkg::sgsel_req_t win;

   wire bus_req;
   wire wr_commit;
   wire lane0_wr;
   wire sel_ctrl;
   wire sel_force;
   wire sel_remote;
   wire sel_status;
   wire sel_refuse;
   wire [CW-1:0] wr_code;
   wire [IW-1:0] wr_idx;
   wire wr_code_some;
   wire wr_code_used;
   wire [N-1:0] agree;
   wire [N-1:0] used_mask;
   wire [N-1:0] held;
   wire [N-1:0] rise;
   wire [N-1:0] blocked;
   wire [N-1:0] remote_onehot;
   wire [N-1:0] cand;
   wire multi_group;
   wire force_release;
   wire auto_event;
   wire force_wr;
   wire remote_wr;
   wire remote_blocked;

   ////////////////////////////////////////////////////////////////////////
   // Request input synchronisers

   // Three stages; a change counts once stages two and three agree
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         sync1_reg <= sgsel_pkg::GROUPS_CLEAR;
         sync2_reg <= sgsel_pkg::GROUPS_CLEAR;
         sync3_reg <= sgsel_pkg::GROUPS_CLEAR;
      end
      else
      begin
         sync1_reg <= GROUP_REQUEST;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   assign agree = ~(sync2_reg ^ sync3_reg);
   assign level_next = (sync2_reg & agree) | (level_reg & ~agree);

   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         level_reg <= sgsel_pkg::GROUPS_CLEAR;
         level_d_reg <= sgsel_pkg::GROUPS_CLEAR;
      end
      else
      begin
         level_reg <= level_next;
         level_d_reg <= level_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Request qualification

   // Groups one through used_cnt+1 are in service
   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_used
         assign used_mask[g] = (IW'(g) <= cfg_reg.used_cnt); // [RL1] [RL15]
      end
   endgenerate

   assign held = level_reg & used_mask; // [RL5]
   assign rise = level_reg & ~level_d_reg & used_mask; // [RL20]

   // A held level masks every lower group; group eight has none below it
   assign blocked[0] = 1'b0;
   generate
      for (g = 1; g < N; g++)
      begin : g_block
         assign blocked[g] = |held[g-1:0]; // [RL17] [RL18] [RL19]
      end
   endgenerate

   assign multi_group = (cfg_reg.used_cnt != sgsel_pkg::USED_RST); // [RL2] [RL3]
   assign force_release = force_en_d_reg & ~cfg_reg.force_en;

   ////////////////////////////////////////////////////////////////////////
   // Wishbone slave decode

   assign bus_req = WB_CYC_I & WB_STB_I;
   // Write lands on the edge where the master samples ack
   assign wr_commit = bus_req & WB_WE_I & ack_reg;
   assign lane0_wr = wr_commit & WB_SEL_I[0];
   assign sel_ctrl = (WB_ADR_I == sgsel_pkg::CTRL_OFS);
   assign sel_force = (WB_ADR_I == sgsel_pkg::FORCE_OFS);
   assign sel_remote = (WB_ADR_I == sgsel_pkg::REMOTE_OFS);
   assign sel_status = (WB_ADR_I == sgsel_pkg::STATUS_OFS);
   assign sel_refuse = (WB_ADR_I == sgsel_pkg::REFUSE_OFS);

   assign wr_code = WB_DAT_I[sgsel_pkg::CODE_LSB +: CW];
   assign wr_code_some = (wr_code != sgsel_pkg::CODE_NONE) && (wr_code <= CW'(N));
   assign wr_idx = IW'(wr_code - CW'(1));
   assign wr_code_used = wr_code_some & used_mask[wr_idx];

   assign force_wr = lane0_wr & sel_force;
   assign remote_wr = lane0_wr & sel_remote;

   // Forced choice only while forcing is on and the group is in service
   assign force_req.valid = force_wr & cfg_reg.force_en & wr_code_used; // [RL9] [RL12] [RL14]
   assign force_req.idx = wr_idx;

   assign remote_blocked = remote_wr & wr_code_used & blocked[wr_idx];
   // Remote change is automatic control: no effect while forcing
   assign remote_req.valid = remote_wr & wr_code_used & ~blocked[wr_idx] & ~cfg_reg.force_en; // [RL16] [RL4]
   assign remote_req.idx = wr_idx;

   ////////////////////////////////////////////////////////////////////////
   // Configuration registers

   always_comb
   begin
      cfg_next = cfg_reg;
      if (lane0_wr & sel_ctrl)
      begin
         cfg_next.force_en = WB_DAT_I[sgsel_pkg::CTRL_FORCE_EN_POS]; // [RL14]
         cfg_next.used_cnt = WB_DAT_I[sgsel_pkg::CTRL_USED_LSB +: IW]; // [RL15]
      end
      if (force_wr)
      begin
         cfg_next.force_code = wr_code_some ? wr_code : sgsel_pkg::CODE_NONE; // [RL12]
      end
      if (remote_wr)
      begin
         cfg_next.remote_code = wr_code_some ? wr_code : sgsel_pkg::CODE_NONE;
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         cfg_reg.force_en <= sgsel_pkg::FORCE_EN_RST;
         cfg_reg.used_cnt <= sgsel_pkg::USED_RST;
         cfg_reg.force_code <= sgsel_pkg::CODE_NONE;
         cfg_reg.remote_code <= sgsel_pkg::CODE_NONE;
         force_en_d_reg <= sgsel_pkg::FORCE_EN_RST;
      end
      else
      begin
         cfg_reg <= cfg_next;
         force_en_d_reg <= cfg_reg.force_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Priority selection

   generate
      for (g = 0; g < N; g++)
      begin : g_remote
         assign remote_onehot[g] = remote_req.valid & (remote_req.idx == IW'(g));
      end
   endgenerate

   // Held levels rejoin on every event so the higher static request wins
   assign cand = (rise | held | remote_onehot) & ~blocked; // [RL6] [RL7]
   assign auto_event = |(rise & ~blocked) | remote_req.valid | force_release; // [RL8] [RL10]

   // Lowest index is highest priority
   always_comb
   begin
      win.valid = 1'b0;
      win.idx = sgsel_pkg::ACTIVE_RST;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (cand[i])
         begin
            win.valid = 1'b1; // [RL6]
            win.idx = IW'(i);
         end
      end
   end

   always_comb
   begin
      active_next = active_reg;
      if (!multi_group)
      begin
         active_next = sgsel_pkg::ACTIVE_RST; // [RL2]
      end
      else if (!used_mask[active_reg])
      begin
         // Group taken out of service: fall back to group one
         active_next = sgsel_pkg::ACTIVE_RST;
      end
      else if (cfg_reg.force_en)
      begin
         if (force_req.valid)
         begin
            active_next = force_req.idx; // [RL4] [RL12]
         end
      end
      else if (auto_event && win.valid)
      begin
         active_next = win.idx; // [RL3] [RL10] [RL20]
      end
      // No winner on release leaves the last group in place [RL13]
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         active_reg <= sgsel_pkg::ACTIVE_RST; // [RL11]
      end
      else
      begin
         active_reg <= active_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Default-load pulses for groups newly in service

   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         used_d_reg <= sgsel_pkg::USED_MASK_RST;
         defaults_reg <= sgsel_pkg::GROUPS_CLEAR;
      end
      else
      begin
         used_d_reg <= used_mask;
         defaults_reg <= used_mask & ~used_d_reg; // [RL15]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Refusal flags, write one to clear; a new refusal beats the clear

   always_comb
   begin
      refuse_next = refuse_reg;
      if (lane0_wr & sel_refuse)
      begin
         refuse_next = refuse_reg & ~WB_DAT_I[2:0];
      end
      if (force_wr & wr_code_some & ~cfg_reg.force_en)
      begin
         refuse_next[sgsel_pkg::REFUSE_FORCE_POS] = 1'b1; // [RL14]
      end
      if (remote_blocked)
      begin
         refuse_next[sgsel_pkg::REFUSE_PRIO_POS] = 1'b1; // [RL16]
      end
      if ((force_wr | remote_wr) & wr_code_some & ~wr_code_used)
      begin
         refuse_next[sgsel_pkg::REFUSE_UNUSED_POS] = 1'b1; // [RL9]
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         refuse_reg <= sgsel_pkg::REFUSE_RST;
      end
      else
      begin
         refuse_reg <= refuse_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data and acknowledge

   always_comb
   begin
      rdata_next = sgsel_pkg::DAT_ZERO;
      if (sel_ctrl)
      begin
         rdata_next[sgsel_pkg::CTRL_FORCE_EN_POS] = cfg_reg.force_en;
         rdata_next[sgsel_pkg::CTRL_USED_LSB +: IW] = cfg_reg.used_cnt;
      end
      else if (sel_force)
      begin
         rdata_next[sgsel_pkg::CODE_LSB +: CW] = cfg_reg.force_code;
      end
      else if (sel_remote)
      begin
         rdata_next[sgsel_pkg::CODE_LSB +: CW] = cfg_reg.remote_code;
      end
      else if (sel_status)
      begin
         // Code one to eight, so group one reads as one
         rdata_next[sgsel_pkg::CODE_LSB +: CW] = CW'(active_reg) + CW'(1); // [RL11]
         rdata_next[sgsel_pkg::STATUS_HELD_LSB +: N] = held;
      end
      else if (sel_refuse)
      begin
         rdata_next[2:0] = refuse_reg;
      end
   end

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         ack_reg <= 1'b0;
         rdata_reg <= sgsel_pkg::DAT_ZERO;
      end
      else
      begin
         ack_reg <= bus_req & ~ack_reg;
         rdata_reg <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign WB_ACK_O = ack_reg;
   assign WB_DAT_O = rdata_reg;
   assign ACTIVE_GROUP = active_reg;
   assign FORCE_ACTIVE = cfg_reg.force_en;
   assign GROUP_LOAD_DEFAULTS = defaults_reg;

   generate
      for (g = 0; g < N; g++)
      begin : g_onehot
         assign ACTIVE_GROUP_ONEHOT[g] = (active_reg == IW'(g));
      end
   endgenerate

endmodule // sgsel_top

// *** pkg/sgsel_pkg.sv ***
// Constants and carrier types for the setting group priority selector
package sgsel_pkg;

   localparam int NUM_GROUPS = 8;
   localparam int IDX_W = 3;
   localparam int CODE_W = 4;
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] FORCE_OFS = 8'h04;
   localparam logic [7:0] REMOTE_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;
   localparam logic [7:0] REFUSE_OFS = 8'h10;

   // Field positions
   localparam int CTRL_FORCE_EN_POS = 0;
   localparam int CTRL_USED_LSB = 4;
   localparam int CODE_LSB = 0;
   localparam int STATUS_HELD_LSB = 8;
   localparam int REFUSE_FORCE_POS = 0;
   localparam int REFUSE_PRIO_POS = 1;
   localparam int REFUSE_UNUSED_POS = 2;

   // Reset values
   localparam logic FORCE_EN_RST = 1'b0;
   localparam logic [IDX_W-1:0] USED_RST = 3'h0;
   localparam logic [IDX_W-1:0] ACTIVE_RST = 3'h0;
   localparam logic [CODE_W-1:0] CODE_NONE = 4'h0;
   localparam logic [2:0] REFUSE_RST = 3'h0;
   localparam logic [NUM_GROUPS-1:0] GROUPS_CLEAR = 8'h00;
   localparam logic [NUM_GROUPS-1:0] USED_MASK_RST = 8'h01;
   localparam logic [DAT_W-1:0] DAT_ZERO = 32'h0000_0000;

   // Software configuration carried as one word
   typedef struct packed {
      logic force_en;
      logic [IDX_W-1:0] used_cnt;
      logic [CODE_W-1:0] force_code;
      logic [CODE_W-1:0] remote_code;
   } sgsel_cfg_t;

   // One request toward the selector
   typedef struct packed {
      logic valid;
      logic [IDX_W-1:0] idx;
   } sgsel_req_t;

endpackage

// *** dv/sgsel_chk_assertions.sv ***
// Concurrent checks on the selector's top-level ports
`timescale 1ns/10ps

module sgsel_chk
(
   input wire logic CORE_CLK,
   input wire logic SRST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [sgsel_pkg::ADR_W-1:0] WB_ADR_I,
   input wire logic WB_ACK_O,
   input wire logic [sgsel_pkg::NUM_GROUPS-1:0] GROUP_REQUEST,
   input wire logic [sgsel_pkg::IDX_W-1:0] ACTIVE_GROUP,
   input wire logic [sgsel_pkg::NUM_GROUPS-1:0] ACTIVE_GROUP_ONEHOT,
   input wire logic FORCE_ACTIVE,
   input wire logic [sgsel_pkg::NUM_GROUPS-1:0] GROUP_LOAD_DEFAULTS
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SRST);

   ////////////////////////////////////////////////////////////////////////////
   onehot_match_a: assert property (ACTIVE_GROUP_ONEHOT == (8'h01 << ACTIVE_GROUP))
      else $error("onehot output disagrees with index");
   reset_state_a: assert property ($fell(SRST) |-> ACTIVE_GROUP == 3'h0 && !FORCE_ACTIVE)
      else $error("wrong state after reset");
   ack_pulse_a: assert property ($rose(WB_CYC_I && WB_STB_I) |=> WB_ACK_O ##1 !WB_ACK_O)
      else $error("bus answer not a single cycle later");
   // Bus writes are excluded: a forced choice itself moves the group
   force_hold_a: assert property (FORCE_ACTIVE && $past(FORCE_ACTIVE) && !$past(WB_ACK_O && WB_WE_I)
      |-> $stable(ACTIVE_GROUP))
      else $error("group moved while forcing");
   // Six samples cover the three-stage input synchroniser plus update
   group_one_a: assert property ((GROUP_REQUEST[0] && !FORCE_ACTIVE) [*6] |-> ACTIVE_GROUP == 3'h0)
      else $error("held group one did not win");
   lower_block_a: assert property ((GROUP_REQUEST[2] && !FORCE_ACTIVE) [*6] |-> ACTIVE_GROUP <= 3'h2)
      else $error("lower group beat a held level");
   load_pulse_a: assert property ((|GROUP_LOAD_DEFAULTS) |-> (!GROUP_LOAD_DEFAULTS[0]
      && ($past(WB_ACK_O) || $past(WB_ACK_O, 2))) ##1 GROUP_LOAD_DEFAULTS == 8'h00)
      else $error("default load pulse wrong");
   force_write_a: assert property ($changed(FORCE_ACTIVE)
      |-> $past(WB_ACK_O && WB_WE_I && WB_ADR_I == sgsel_pkg::CTRL_OFS))
      else $error("force flag moved without a write");
endmodule // sgsel_chk

bind sgsel_top sgsel_chk u_chk (.CORE_CLK(CORE_CLK), .SRST(SRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
   .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_ACK_O(WB_ACK_O), .GROUP_REQUEST(GROUP_REQUEST),
   .ACTIVE_GROUP(ACTIVE_GROUP), .ACTIVE_GROUP_ONEHOT(ACTIVE_GROUP_ONEHOT), .FORCE_ACTIVE(FORCE_ACTIVE),
   .GROUP_LOAD_DEFAULTS(GROUP_LOAD_DEFAULTS));

// *** dv/sgsel_src.sv ***
// Request source model standing in for logic and digital inputs
`timescale 1ns/10ps

module sgsel_src
(
   input wire logic clk,
   output logic [7:0] req
);
   logic [7:0] lvl = 8'h00;
   logic [7:0] pls = 8'h00;

   assign req = lvl | pls;

   // Two cycles is the shortest pulse: the input filter wants two agreeing samples
   task automatic pulse(input int i);
      @(posedge clk);
      pls <= 8'h01 << i;
      repeat (2) @(posedge clk);
      pls <= 8'h00;
   endtask

   task automatic hold(input logic [7:0] m);
      @(posedge clk);
      lvl <= m;
   endtask
endmodule // sgsel_src

// *** dv/tb.sv ***
// Self-checking bench for the setting group selector
`timescale 1ns/10ps

module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic [3:0] sel = 4'hf;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0000_0000;
   logic [31:0] rd;
   logic [31:0] dato;
   logic ack;
   logic [7:0] req;
   logic [2:0] act;
   logic [7:0] oh;
   logic fa;
   logic [7:0] ld;
   logic [7:0] ld_seen = 8'h00;
   int errors = 0;
   int n_checks = 0;

   initial
   begin
      forever #5 clk = ~clk;
   end

   always @(posedge clk) ld_seen <= ld_seen | ld;

   sgsel_top uut (.CORE_CLK(clk), .SRST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(dato), .WB_ACK_O(ack), .GROUP_REQUEST(req),
      .ACTIVE_GROUP(act), .ACTIVE_GROUP_ONEHOT(oh), .FORCE_ACTIVE(fa), .GROUP_LOAD_DEFAULTS(ld));
   sgsel_src src (.clk(clk), .req(req));

   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic ck_act(input logic [2:0] e);
      chk({29'h0, act}, {29'h0, e});
      chk({24'h0, oh}, 32'h1 << e);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Holds the request until ack is sampled, then one idle cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      sel <= s;
      we <= w;
      adr <= a;
      wd <= d;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (ack !== 1'b1 && k < 50);
      rd = dato;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (k >= 50)
      begin
         errors++;
         tally_and_finish();
      end
      else
      begin
         @(posedge clk);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20, 8'hff};
      foreach (ofs[i])
      begin
         wb(1'b0, ofs[i], 32'h0);
         chk(rd, 32'h0);
      end
      wb(1'b0, sgsel_pkg::STATUS_OFS, 32'h0);
      chk(rd, 32'h0000_0001);
      // Only group one is in service, so a remote request for group three is refused
      wb(1'b1, sgsel_pkg::REMOTE_OFS, 32'h0000_0003);
      wb(1'b0, sgsel_pkg::REFUSE_OFS, 32'h0);
      chk(rd, 32'h0000_0004);
      wb(1'b1, sgsel_pkg::REFUSE_OFS, 32'h0000_0007);
      src.pulse(2);
      settle(5);
      ck_act(3'h0);
      $display("test reset done");
   endtask

   task automatic t_pulse();
      // Bits outside the control fields must be ignored
      wb(1'b1, sgsel_pkg::CTRL_OFS, 32'hffff_fffe);
      settle(2);
      chk({24'h0, ld_seen}, 32'h0000_00fe);
      wb(1'b0, sgsel_pkg::CTRL_OFS, 32'h0);
      chk(rd, 32'h0000_0070);
      src.pulse(4);
      settle(3);
      ck_act(3'h0);
      settle(1);
      ck_act(3'h4);
      settle(4);
      ck_act(3'h4);
      $display("test pulse done");
   endtask

   task automatic t_level();
      src.hold(8'h24);
      settle(6);
      ck_act(3'h2);
      src.pulse(4);
      settle(5);
      ck_act(3'h2);
      wb(1'b0, sgsel_pkg::STATUS_OFS, 32'h0);
      chk(rd, 32'h0000_2403);
      src.pulse(1);
      settle(5);
      ck_act(3'h1);
      wb(1'b1, sgsel_pkg::REMOTE_OFS, 32'h0000_0006);
      wb(1'b0, sgsel_pkg::REFUSE_OFS, 32'h0);
      chk(rd, 32'h0000_0002);
      ck_act(3'h1);
      wb(1'b1, sgsel_pkg::REFUSE_OFS, 32'h0000_0007);
      src.hold(8'h80);
      settle(6);
      ck_act(3'h7);
      src.pulse(6);
      settle(5);
      ck_act(3'h6);
      src.pulse(5);
      settle(5);
      ck_act(3'h5);
      src.hold(8'h01);
      settle(6);
      src.pulse(3);
      wb(1'b1, sgsel_pkg::REMOTE_OFS, 32'h0000_0002);
      settle(5);
      ck_act(3'h0);
      wb(1'b0, sgsel_pkg::REFUSE_OFS, 32'h0);
      chk(rd, 32'h0000_0002);
      wb(1'b1, sgsel_pkg::REFUSE_OFS, 32'h0000_0007);
      src.hold(8'h00);
      $display("test level done");
   endtask

   task automatic t_force();
      // Byte lane zero disabled: the control write must not land
      wb(1'b1, sgsel_pkg::CTRL_OFS, 32'h0000_0071, 4'he);
      chk({31'h0, fa}, 32'h0);
      wb(1'b1, sgsel_pkg::FORCE_OFS, 32'h0000_0003);
      wb(1'b0, sgsel_pkg::REFUSE_OFS, 32'h0);
      chk(rd, 32'h0000_0001);
      wb(1'b0, sgsel_pkg::FORCE_OFS, 32'h0);
      chk(rd, 32'h0000_0003);
      ck_act(3'h0);
      wb(1'b1, sgsel_pkg::REFUSE_OFS, 32'h0000_0007);
      src.hold(8'h08);
      wb(1'b1, sgsel_pkg::CTRL_OFS, 32'h0000_0071);
      chk({31'h0, fa}, 32'h1);
      wb(1'b1, sgsel_pkg::FORCE_OFS, 32'h0000_0002);
      ck_act(3'h1);
      src.pulse(0);
      settle(5);
      ck_act(3'h1);
      wb(1'b1, sgsel_pkg::CTRL_OFS, 32'h0000_0070);
      settle(2);
      ck_act(3'h3);
      src.hold(8'h00);
      wb(1'b1, sgsel_pkg::CTRL_OFS, 32'h0000_0071);
      wb(1'b1, sgsel_pkg::FORCE_OFS, 32'h0000_0006);
      wb(1'b1, sgsel_pkg::CTRL_OFS, 32'h0000_0070);
      settle(6);
      ck_act(3'h5);
      rst <= 1'b1;
      settle(3);
      rst <= 1'b0;
      settle(1);
      ck_act(3'h0);
      chk({31'h0, fa}, 32'h0);
      $display("test force done");
   endtask

   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_pulse();
      t_level();
      t_force();
      tally_and_finish();
   end
endmodule // tb
